// File: pkg/ufl_pkg.sv
package ufl_pkg;

  // ****************************************
  // fifo geometry and entry layout
  // ****************************************
  localparam int unsigned FIFO_AW = 6;
  localparam logic [6:0] FIFO_FULL_CNT = 7'h40;
  localparam int unsigned ENT_PE = 8;
  localparam int unsigned ENT_FE = 9;
  localparam int unsigned ENT_BRK = 10;
  localparam int unsigned RX_ENT_W = 11;
  localparam int unsigned TX_ENT_W = 8;

  // ****************************************
  // register indices, byte address = 4 * index
  // ****************************************
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_DIV_HIGH = 3'h1;
  localparam logic [2:0] IDX_FIFO_CTRL = 3'h2;
  localparam logic [2:0] IDX_LINE_FMT = 3'h3;
  localparam logic [2:0] IDX_LINE_STAT = 3'h5;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned FCR_EN = 0;
  localparam int unsigned FCR_RXCLR = 1;
  localparam int unsigned FCR_TXCLR = 2;
  localparam int unsigned FCR_DMA = 3;
  localparam int unsigned FCR_TXTRIG = 4;
  localparam int unsigned FCR_RXTRIG = 6;
  localparam int unsigned LCR_STOP = 2;
  localparam int unsigned LCR_PAR_EN = 3;
  localparam int unsigned LCR_PAR_EVEN = 4;
  localparam int unsigned LCR_PAR_FORCE = 5;
  localparam int unsigned LCR_BREAK = 6;
  localparam int unsigned LCR_DLAB = 7;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0][6:0] TX_TRIG_LVL = {7'h38, 7'h20, 7'h10, 7'h08};
  localparam logic [3:0][6:0] RX_TRIG_LVL = {7'h3c, 7'h38, 7'h10, 7'h08};

  // ****************************************
  // carriers and states
  // ****************************************
  typedef struct packed {
    logic awvalid;
    logic [4:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [4:0] araddr;
    logic rready;
  } ufl_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ufl_axi_rsp_type;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufl_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT_HIGH}
    ufl_rx_state_type;

endpackage : ufl_pkg

// File: src/ufl_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module ufl_fifo #(
  parameter int unsigned W = 8
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clr_i,
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  input wire logic pop_i,
  output logic [W-1:0] head_o,
  output logic [6:0] count_o
);

  typedef struct packed {
    logic [63:0][W-1:0] mem;
    logic [ufl_pkg::FIFO_AW-1:0] wr;
    logic [ufl_pkg::FIFO_AW-1:0] rd;
    logic [6:0] cnt;
  } ufl_fifo_state_type;

  ufl_fifo_state_type s_reg;
  ufl_fifo_state_type s_next;
  logic push_ok;
  logic pop_ok;

  always_comb begin
    s_next = s_reg;
    push_ok = push_i && (s_reg.cnt != ufl_pkg::FIFO_FULL_CNT);
    pop_ok = pop_i && (s_reg.cnt != 7'h00);
    if (clr_i) begin
      // clear wins over push and pop
      s_next.wr = '0;
      s_next.rd = '0;
      s_next.cnt = '0;
    end else begin
      if (push_ok) begin
        s_next.mem[s_reg.wr] = data_i;
        s_next.wr = s_reg.wr + 6'h01;
      end
      if (pop_ok) begin
        s_next.rd = s_reg.rd + 6'h01;
      end
      s_next.cnt = s_reg.cnt + {6'h00, push_ok} - {6'h00, pop_ok};
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign head_o = s_reg.mem[s_reg.rd];
  assign count_o = s_reg.cnt;

endmodule : ufl_fifo

`default_nettype wire

// File: src/ufl_top.sv
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module ufl_top (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire ufl_pkg::ufl_axi_req_type axi_req_i,
  output ufl_pkg::ufl_axi_rsp_type axi_rsp_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic tx_trig_o,
  output logic rx_trig_o,
  output logic dma_mode_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ufl_pkg::ufl_axi_rsp_type rsp;
    logic aw_got;
    logic [4:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane;
    logic fifo_en;
    logic dma_mode;
    logic [1:0] tx_trig_sel;
    logic [1:0] rx_trig_sel;
    logic [7:0] line_format_control;
    logic [15:0] div;
    logic overrun;
    logic [6:0] err_cnt;
    ufl_pkg::ufl_tx_state_type tx_st;
    logic [7:0] tx_shift;
    logic tx_par;
    logic [2:0] tx_bit;
    logic [17:0] tx_tmr;
    logic tx_line;
    logic tx_out;
    ufl_pkg::ufl_rx_state_type rx_st;
    logic [7:0] rx_shift;
    logic [2:0] rx_bit;
    logic [17:0] rx_tmr;
    logic rx_pe;
    logic rx_zero;
    logic tx_trig;
    logic rx_trig;
  } ufl_top_state_type;

  ufl_top_state_type s_reg;
  ufl_top_state_type s_next;

  logic wr_do, rd_do, dlab, tx_tick, rx_tick, rx_full;
  logic tx_push, tx_pop, tx_clr, rx_push, rx_push_ok, rx_pop, rx_clr;
  logic [17:0] per, stop_len;
  logic [2:0] last_bit;
  logic [7:0] line_status, rx_word;
  logic [10:0] rx_wdata, rx_head;
  logic [7:0] tx_head;
  logic [6:0] tx_cnt, rx_cnt;

  function automatic logic ufl_par(input logic [7:0] d, input logic [7:0] f);
    logic [7:0] m;
    m = 8'hff >> (2'd3 - f[1:0]);
    ufl_par = f[ufl_pkg::LCR_PAR_FORCE] ? !f[ufl_pkg::LCR_PAR_EVEN] :
              (f[ufl_pkg::LCR_PAR_EVEN] ? ^(d & m) : !(^(d & m)));
  endfunction : ufl_par

  // ****************************************
  // fifos
  // ****************************************
  ufl_fifo #(.W(ufl_pkg::TX_ENT_W)) u_tx_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .clr_i(tx_clr),
    .push_i(tx_push),
    .data_i(s_reg.w_data),
    .pop_i(tx_pop),
    .head_o(tx_head),
    .count_o(tx_cnt)
  );

  ufl_fifo #(.W(ufl_pkg::RX_ENT_W)) u_rx_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .clr_i(rx_clr),
    .push_i(rx_push_ok),
    .data_i(rx_wdata),
    .pop_i(rx_pop),
    .head_o(rx_head),
    .count_o(rx_cnt)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_clr = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_clr = 1'b0;
    rx_wdata = '0;
    rx_word = s_reg.rx_shift;
    dlab = s_reg.line_format_control[ufl_pkg::LCR_DLAB];
    per = (s_reg.div == 16'h0000) ? 18'h0_0001 : {2'b00, s_reg.div};
    last_bit = {1'b1, s_reg.line_format_control[1:0]};
    if (!s_reg.line_format_control[ufl_pkg::LCR_STOP]) begin
      stop_len = per;
    end else if (s_reg.line_format_control[1:0] == 2'b00) begin
      stop_len = per + (per >> 1);
    end else begin
      stop_len = per << 1;
    end
    rx_full = s_reg.fifo_en ? (rx_cnt == ufl_pkg::FIFO_FULL_CNT) : (rx_cnt != 7'h00);
    line_status = {s_reg.err_cnt != 7'h00,
           (tx_cnt == 7'h00) && (s_reg.tx_st == ufl_pkg::TX_IDLE),
           tx_cnt == 7'h00,
           (rx_cnt != 7'h00) ? rx_head[ufl_pkg::ENT_BRK:ufl_pkg::ENT_PE] : 3'b000,
           s_reg.overrun,
           rx_cnt != 7'h00};
    wr_do = s_reg.aw_got && s_reg.w_got && !s_reg.rsp.bvalid;
    rd_do = axi_req_i.arvalid && s_reg.rsp.arready;

    // write path
    if (axi_req_i.awvalid && s_reg.rsp.awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && s_reg.rsp.wready) begin
      s_next.w_got = 1'b1;
      s_next.w_data = axi_req_i.wdata[7:0];
      s_next.w_lane = axi_req_i.wstrb[0];
    end
    if (s_reg.rsp.bvalid && axi_req_i.bready) begin
      s_next.rsp.bvalid = 1'b0;
    end
    if (wr_do) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.rsp.bvalid = 1'b1;
      s_next.rsp.bresp = ufl_pkg::RESP_OKAY;
      case (s_reg.aw_addr[4:2])
        ufl_pkg::IDX_DATA: begin
          if (dlab && s_reg.w_lane) begin
            s_next.div[7:0] = s_reg.w_data;
          end else if (s_reg.w_lane) begin
            tx_push = (tx_cnt != ufl_pkg::FIFO_FULL_CNT);
          end
        end
        ufl_pkg::IDX_DIV_HIGH: begin
          if (!dlab) begin
            s_next.rsp.bresp = ufl_pkg::RESP_SLVERR;
          end else if (s_reg.w_lane) begin
            s_next.div[15:8] = s_reg.w_data;
          end
        end
        ufl_pkg::IDX_FIFO_CTRL: begin
          if (s_reg.w_lane) begin
            s_next.fifo_en = s_reg.w_data[ufl_pkg::FCR_EN];
            rx_clr = s_reg.w_data[ufl_pkg::FCR_RXCLR];
            tx_clr = s_reg.w_data[ufl_pkg::FCR_TXCLR];
            s_next.dma_mode = s_reg.w_data[ufl_pkg::FCR_DMA];
            s_next.tx_trig_sel = s_reg.w_data[ufl_pkg::FCR_TXTRIG +: 2];
            s_next.rx_trig_sel = s_reg.w_data[ufl_pkg::FCR_RXTRIG +: 2];
          end
        end
        ufl_pkg::IDX_LINE_FMT: begin
          if (s_reg.w_lane) begin
            s_next.line_format_control = s_reg.w_data;
          end
        end
        default: begin
          s_next.rsp.bresp = ufl_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_next.rsp.awready = !s_next.aw_got && !s_next.rsp.bvalid;
    s_next.rsp.wready = !s_next.w_got && !s_next.rsp.bvalid;

    // read path
    if (s_reg.rsp.rvalid && axi_req_i.rready) begin
      s_next.rsp.rvalid = 1'b0;
    end
    if (rd_do) begin
      s_next.rsp.rvalid = 1'b1;
      s_next.rsp.rresp = ufl_pkg::RESP_OKAY;
      s_next.rsp.rdata = '0;
      case (axi_req_i.araddr[4:2])
        ufl_pkg::IDX_DATA: begin
          if (dlab) begin
            s_next.rsp.rdata[7:0] = s_reg.div[7:0];
          end else begin
            s_next.rsp.rdata[7:0] = (rx_cnt != 7'h00) ? rx_head[7:0] : 8'h00;
            rx_pop = (rx_cnt != 7'h00);
          end
        end
        ufl_pkg::IDX_DIV_HIGH: begin
          if (dlab) begin
            s_next.rsp.rdata[7:0] = s_reg.div[15:8];
          end else begin
            s_next.rsp.rresp = ufl_pkg::RESP_SLVERR;
          end
        end
        ufl_pkg::IDX_LINE_FMT: begin
          s_next.rsp.rdata[7:0] = s_reg.line_format_control;
        end
        ufl_pkg::IDX_LINE_STAT: begin
          s_next.rsp.rdata[7:0] = line_status;
          s_next.overrun = 1'b0;
        end
        default: begin
          // fifo control reads back nothing
          s_next.rsp.rresp = ufl_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_next.rsp.arready = !s_next.rsp.rvalid;

    // transmitter
    tx_tick = (s_reg.tx_tmr == 18'h0_0000);
    if (!tx_tick) begin
      s_next.tx_tmr = s_reg.tx_tmr - 18'h0_0001;
    end
    unique case (s_reg.tx_st)
      ufl_pkg::TX_IDLE: begin
        s_next.tx_line = 1'b1;
        if ((tx_cnt != 7'h00) && !tx_clr) begin
          tx_pop = 1'b1;
          s_next.tx_shift = tx_head;
          s_next.tx_par = ufl_par(tx_head, s_reg.line_format_control);
          s_next.tx_line = 1'b0;
          s_next.tx_bit = 3'h0;
          s_next.tx_tmr = per - 18'h0_0001;
          s_next.tx_st = ufl_pkg::TX_START;
        end
      end
      ufl_pkg::TX_START: begin
        if (tx_tick) begin
          s_next.tx_line = s_reg.tx_shift[0];
          s_next.tx_tmr = per - 18'h0_0001;
          s_next.tx_st = ufl_pkg::TX_DATA;
        end
      end
      ufl_pkg::TX_DATA: begin
        if (tx_tick && (s_reg.tx_bit == last_bit)) begin
          if (s_reg.line_format_control[ufl_pkg::LCR_PAR_EN]) begin
            s_next.tx_line = s_reg.tx_par;
            s_next.tx_tmr = per - 18'h0_0001;
            s_next.tx_st = ufl_pkg::TX_PAR;
          end else begin
            s_next.tx_line = 1'b1;
            s_next.tx_tmr = stop_len - 18'h0_0001;
            s_next.tx_st = ufl_pkg::TX_STOP;
          end
        end else if (tx_tick) begin
          s_next.tx_shift = s_reg.tx_shift >> 1;
          s_next.tx_line = s_reg.tx_shift[1];
          s_next.tx_bit = s_reg.tx_bit + 3'h1;
          s_next.tx_tmr = per - 18'h0_0001;
        end
      end
      ufl_pkg::TX_PAR: begin
        if (tx_tick) begin
          s_next.tx_line = 1'b1;
          s_next.tx_tmr = stop_len - 18'h0_0001;
          s_next.tx_st = ufl_pkg::TX_STOP;
        end
      end
      ufl_pkg::TX_STOP: begin
        if (tx_tick) begin
          s_next.tx_st = ufl_pkg::TX_IDLE;
        end
      end
    endcase
    s_next.tx_out = s_next.line_format_control[ufl_pkg::LCR_BREAK] ? 1'b0 : s_next.tx_line;

    // receiver
    rx_tick = (s_reg.rx_tmr == 18'h0_0000);
    if (!rx_tick) begin
      s_next.rx_tmr = s_reg.rx_tmr - 18'h0_0001;
    end
    unique case (s_reg.rx_st)
      ufl_pkg::RX_IDLE: begin
        if (!rx_i) begin
          s_next.rx_tmr = per >> 1;
          s_next.rx_st = ufl_pkg::RX_START;
        end
      end
      ufl_pkg::RX_START: begin
        if (rx_tick && rx_i) begin
          s_next.rx_st = ufl_pkg::RX_IDLE;
        end else if (rx_tick) begin
          s_next.rx_tmr = per - 18'h0_0001;
          s_next.rx_bit = 3'h0;
          s_next.rx_shift = 8'h00;
          s_next.rx_zero = 1'b1;
          s_next.rx_pe = 1'b0;
          s_next.rx_st = ufl_pkg::RX_DATA;
        end
      end
      ufl_pkg::RX_DATA: begin
        if (rx_tick) begin
          rx_word = {rx_i, s_reg.rx_shift[7:1]};
          s_next.rx_zero = s_reg.rx_zero && !rx_i;
          s_next.rx_tmr = per - 18'h0_0001;
          s_next.rx_bit = s_reg.rx_bit + 3'h1;
          s_next.rx_shift = rx_word;
          if (s_reg.rx_bit == last_bit) begin
            s_next.rx_shift = rx_word >> (2'd3 - s_reg.line_format_control[1:0]);
            s_next.rx_st = s_reg.line_format_control[ufl_pkg::LCR_PAR_EN] ? ufl_pkg::RX_PAR : ufl_pkg::RX_STOP;
          end
        end
      end
      ufl_pkg::RX_PAR: begin
        if (rx_tick) begin
          s_next.rx_pe = (rx_i != ufl_par(s_reg.rx_shift, s_reg.line_format_control));
          s_next.rx_zero = s_reg.rx_zero && !rx_i;
          s_next.rx_tmr = per - 18'h0_0001;
          s_next.rx_st = ufl_pkg::RX_STOP;
        end
      end
      ufl_pkg::RX_STOP: begin
        if (rx_tick) begin
          rx_push = 1'b1;
          rx_wdata[ufl_pkg::ENT_BRK] = s_reg.rx_zero && !rx_i;
          rx_wdata[ufl_pkg::ENT_FE] = !rx_i;
          rx_wdata[ufl_pkg::ENT_PE] = s_reg.rx_pe;
          rx_wdata[7:0] = (s_reg.rx_zero && !rx_i) ? 8'h00 : s_reg.rx_shift;
          s_next.rx_st = rx_i ? ufl_pkg::RX_IDLE : ufl_pkg::RX_WAIT_HIGH;
        end
      end
      ufl_pkg::RX_WAIT_HIGH: begin
        if (rx_i) begin
          s_next.rx_st = ufl_pkg::RX_IDLE;
        end
      end
      default: begin
        s_next.rx_st = ufl_pkg::RX_IDLE;
      end
    endcase
    rx_push_ok = rx_push && !rx_full && !rx_clr;
    if (rx_push && rx_full) begin
      s_next.overrun = 1'b1;
    end
    if (rx_clr) begin
      s_next.err_cnt = 7'h00;
    end else begin
      s_next.err_cnt = s_reg.err_cnt
        + {6'h00, rx_push_ok && (rx_wdata[ufl_pkg::ENT_BRK:ufl_pkg::ENT_PE] != 3'b000)}
        - {6'h00, rx_pop && (rx_head[ufl_pkg::ENT_BRK:ufl_pkg::ENT_PE] != 3'b000)};
    end
    s_next.tx_trig = (ufl_pkg::FIFO_FULL_CNT - tx_cnt) >= ufl_pkg::TX_TRIG_LVL[s_reg.tx_trig_sel];
    s_next.rx_trig = rx_cnt >= ufl_pkg::RX_TRIG_LVL[s_reg.rx_trig_sel];
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.line_format_control <= ufl_pkg::LCR_RESET;
      s_reg.div <= ufl_pkg::DIV_RESET;
      s_reg.tx_line <= 1'b1;
      s_reg.tx_out <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign axi_rsp_o = s_reg.rsp;
  assign tx_o = s_reg.tx_out;
  assign tx_trig_o = s_reg.tx_trig;
  assign rx_trig_o = s_reg.rx_trig;
  assign dma_mode_o = s_reg.dma_mode;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  logic rd_stat;
  assign rd_stat = rd_do && (axi_req_i.araddr[4:2] == ufl_pkg::IDX_LINE_STAT);

  chk_tx_break_low: assert property (s_reg.line_format_control[ufl_pkg::LCR_BREAK] |-> !tx_o)
    else $error("break set but line not low");
  chk_stat_no_pop: assert property (rd_stat && !rx_push_ok && !rx_clr
    |=> rx_cnt == $past(rx_cnt))
    else $error("status read changed rx count");
  chk_data_pop: assert property (rd_do && !dlab && (axi_req_i.araddr[4:2] == ufl_pkg::IDX_DATA)
    && (rx_cnt != 7'h00) && !rx_push_ok && !rx_clr |=> rx_cnt == $past(rx_cnt) - 7'h01)
    else $error("data read did not pop rx fifo");
  chk_rx_clear: assert property (rx_clr |=> rx_cnt == 7'h00 && s_reg.err_cnt == 7'h00)
    else $error("rx clear left entries");
  chk_tx_drop: assert property (wr_do && (tx_cnt == ufl_pkg::FIFO_FULL_CNT) && !tx_pop
    && !tx_clr |=> tx_cnt == ufl_pkg::FIFO_FULL_CNT)
    else $error("full tx fifo changed on write");
  chk_stat_ready: assert property (rd_stat |=> axi_rsp_o.rdata[0] == ($past(rx_cnt) != 7'h00)
    && axi_rsp_o.rdata[7] == ($past(s_reg.err_cnt) != 7'h00))
    else $error("status data or error bit wrong");
  chk_overrun_set: assert property (rx_push && rx_full |=> s_reg.overrun)
    else $error("overrun not flagged");
  chk_tx_start: assert property (s_reg.tx_st == ufl_pkg::TX_IDLE && tx_cnt != 7'h00 && !tx_clr
    && !s_reg.line_format_control[ufl_pkg::LCR_BREAK] && !s_next.line_format_control[ufl_pkg::LCR_BREAK] |=> !tx_o)
    else $error("start bit not driven");

  cov_rx_char: cover property (rx_push_ok);
  cov_rx_break: cover property (rx_push_ok && rx_wdata[ufl_pkg::ENT_BRK]);
  cov_tx_full: cover property (tx_cnt == ufl_pkg::FIFO_FULL_CNT);

endmodule : ufl_top

`default_nettype wire

// File: dv/ufl_serial_peer.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// far-end serial device
// ****************************************
module ufl_serial_peer #(
  parameter int DIV = 16
) (
  input wire logic clk_sys_i,
  input wire logic line_i,
  output logic line_o
);
  int nfr = 9;
  int div = DIV;
  logic [11:0] got_q[$];

  initial line_o = 1'b1;

  // start bit, then bits lsb first incl. parity and stops, then idle high
  task automatic send(input logic [11:0] bits, input int n);
    @(posedge clk_sys_i) line_o <= 1'b0;
    repeat (div) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      line_o <= bits[i];
      repeat (div) @(posedge clk_sys_i);
    end
    line_o <= 1'b1;
    repeat (2 * div) @(posedge clk_sys_i);
  endtask : send

  // capture nfr bits after each start, sampled mid-bit
  always begin
    logic [11:0] v;
    @(negedge line_i);
    v = '0;
    repeat (div / 2) @(posedge clk_sys_i);
    for (int i = 0; i < nfr; i++) begin
      repeat (div) @(posedge clk_sys_i);
      v[i] = line_i;
    end
    got_q.push_back(v);
  end
endmodule : ufl_serial_peer

`default_nettype wire

// File: dv/uart_fifo_line_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module uart_fifo_line_control_tb_top;
  localparam int DIV = 16;
  localparam logic [1:0] OK = ufl_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = ufl_pkg::RESP_SLVERR;
  localparam logic [7:0] LCRS [8] = '{8'h03, 8'h0b, 8'h1b, 8'h2b, 8'h3b, 8'h00, 8'h05, 8'h0e};
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  ufl_pkg::ufl_axi_req_type req = '0;
  ufl_pkg::ufl_axi_rsp_type rsp;
  logic rx, tx, tx_trig, rx_trig, dma_mode;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];

  always #5 clk_sys_i = ~clk_sys_i;

  ufl_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .rx_i(rx), .tx_o(tx), .tx_trig_o(tx_trig), .rx_trig_o(rx_trig), .dma_mode_o(dma_mode));
  ufl_serial_peer #(.DIV(DIV)) PEER (.clk_sys_i(clk_sys_i), .line_i(tx), .line_o(rx));

  // ****************************************
  // checking and reporting
  // ****************************************
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      give_verdict();
    end
  end

  // ****************************************
  // register bus master
  // ****************************************
  task automatic wr(input logic [2:0] idx, input logic [7:0] v, input logic [1:0] er = OK);
    @(posedge clk_sys_i);
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= {24'h00_0000, v};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
  endtask : wr

  task automatic rd(input logic [2:0] idx, input logic [7:0] ev, input logic [1:0] er = OK,
                    input logic [7:0] m = 8'hff);
    @(posedge clk_sys_i);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    req.rready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    chk($sformatf("rresp %0d", idx), {30'h0, er}, {30'h0, rsp.rresp});
    if (er == OK) chk($sformatf("rdata %0d", idx), {24'h00_0000, ev & m}, rsp.rdata & {24'h00_0000, m});
  endtask : rd

  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask : tdone

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int unsigned s;
    int nb;
    logic [7:0] line_format_control, d;
    logic p;
    logic [11:0] e;
    s = $urandom(2);
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    chk("dma_mode", 0, {31'h0, dma_mode});
    rd(5, 8'h60);
    rd(3, 8'h00);
    rd(2, 8'h00, ERR);
    rd(1, 8'h00, ERR);
    rd(7, 8'h00, ERR);
    tdone("reset");
    wr(3, 8'h80);
    wr(0, 8'h10);
    wr(1, 8'h00);
    rd(1, 8'h00);
    rd(0, 8'h10);
    tdone("divisor");
    for (int i = 0; i < 8; i++) begin
      line_format_control = LCRS[i];
      nb = int'(line_format_control[1:0]) + 5;
      d = 8'($urandom) & 8'(8'hff >> (8 - nb));
      p = line_format_control[5] ? ~line_format_control[4] : (line_format_control[4] ? ^d : ~^d);
      PEER.nfr = nb + int'(line_format_control[3]) + 1;
      e = 12'(d) | (12'(p & line_format_control[3]) << nb) | (12'h001 << (nb + int'(line_format_control[3])));
      wr(3, line_format_control);
      wr(0, d);
      for (int k = 0; k < 400 && PEER.got_q.size() == 0; k++) @(posedge clk_sys_i);
      chk("tx frame", e, PEER.got_q.size() ? PEER.got_q.pop_front() : 'x);
      repeat (4 * DIV) @(posedge clk_sys_i);
    end
    tdone("tx format");
    wr(3, 8'h43);
    repeat (DIV) @(posedge clk_sys_i);
    chk("tx break", 0, {31'h0, tx});
    wr(3, 8'h1b);
    repeat (12 * DIV) @(posedge clk_sys_i);
    chk("tx idle", 1, {31'h0, tx});
    PEER.got_q.delete();
    tdone("tx break");
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      p = ^d ^ i[0];
      PEER.send({2'b00, 1'b1, p, d}, 10);
      rd(5, i ? 8'he5 : 8'h61);
      rd(5, i ? 8'he5 : 8'h61);
      rd(0, d);
      rd(5, 8'h60);
    end
    wr(3, 8'h03);
    PEER.send(12'h000, 9);
    rd(5, 8'hf9);
    rd(0, 8'h00);
    tdone("rx errors");
    d = 8'($urandom);
    PEER.send({3'b000, 1'b1, d}, 9);
    PEER.send({3'b000, 1'b1, ~d}, 9);
    rd(5, 8'h63);
    rd(5, 8'h61);
    rd(0, d);
    tdone("overrun");
    wr(2, 8'h09);
    chk("dma_mode", 1, {31'h0, dma_mode});
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      exp_q.push_back(d);
      PEER.send({3'b000, 1'b1, d}, 9);
    end
    chk("rx_trig", 1, {31'h0, rx_trig});
    rd(5, 8'h61);
    wr(2, 8'h49);
    repeat (3) @(posedge clk_sys_i);
    chk("rx_trig", 0, {31'h0, rx_trig});
    rd(0, exp_q.pop_front());
    rd(0, exp_q.pop_front());
    wr(2, 8'h0b);
    rd(5, 8'h60);
    chk("rx_trig", 0, {31'h0, rx_trig});
    tdone("rx fifo");
    chk("tx_trig", 1, {31'h0, tx_trig});
    wr(3, 8'h83);
    wr(0, 8'h20);
    wr(3, 8'h03);
    PEER.div = 32;
    PEER.nfr = 9;
    PEER.got_q.delete();
    exp_q.delete();
    // one frame outlasts 66 writes: one byte shifting, 64 stored, last dropped
    for (int i = 0; i < 66; i++) begin
      d = 8'($urandom);
      if (i < 65) exp_q.push_back(d);
      wr(0, d);
    end
    chk("tx_trig", 0, {31'h0, tx_trig});
    rd(5, 8'h00);
    for (int i = 0; i < 65; i++) begin
      for (int k = 0; k < 800 && PEER.got_q.size() == 0; k++) @(posedge clk_sys_i);
      e = PEER.got_q.size() ? PEER.got_q.pop_front() : 'x;
      chk("tx fifo byte", {24'h00_0001, exp_q.pop_front()}, {20'h0_0000, e});
    end
    repeat (12 * PEER.div) @(posedge clk_sys_i);
    chk("tx dropped", 0, PEER.got_q.size());
    rd(5, 8'h60);
    for (int i = 0; i < 10; i++) wr(0, 8'($urandom));
    wr(2, 8'h31);
    repeat (3) @(posedge clk_sys_i);
    chk("tx_trig", 0, {31'h0, tx_trig});
    wr(2, 8'h35);
    repeat (3) @(posedge clk_sys_i);
    chk("tx_trig", 1, {31'h0, tx_trig});
    rd(5, 8'h20, OK, 8'h3f);
    repeat (12 * PEER.div) @(posedge clk_sys_i);
    rd(5, 8'h60);
    tdone("tx fifo");
    give_verdict();
  end
endmodule : uart_fifo_line_control_tb_top

`default_nettype wire
